//--- pkg/adc_ctrl_pkg.sv
/*
  Shared constants for the converter mode, trigger and limit-check control block:
  register indices, field positions, reset values, conversion lengths and state codes.
  Assumes an 8-bit register port with a 3-bit word index.
*/
package adc_ctrl_pkg;

  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 3;
  localparam int RESULT_W = 10;
  localparam int STATUS_W = 2;
  localparam int DIV_W    = 7;
  localparam int COUNT_W  = 5;

  localparam logic [2:0] OFS_TIMING  = 3'h0;
  localparam logic [2:0] OFS_TRIGGER = 3'h1;
  localparam logic [2:0] OFS_REFCHK  = 3'h2;
  localparam logic [2:0] OFS_UPPER   = 3'h3;
  localparam logic [2:0] OFS_LOWER   = 3'h4;
  localparam logic [2:0] OFS_STATUS  = 3'h5;
  localparam logic [2:0] OFS_CLEAR   = 3'h6;
  localparam logic [2:0] OFS_ENABLE  = 3'h7;

  localparam int BIT_RUN      = 7;
  localparam int BIT_SCAN     = 6;
  localparam int FLD_DIV_LSB  = 3;
  localparam int FLD_OPM_LSB  = 1;
  localparam int BIT_COMP     = 0;
  localparam int FLD_TRGM_LSB = 6;
  localparam int BIT_ONESHOT  = 5;
  localparam int FLD_TSRC_LSB = 0;
  localparam int FLD_PREF_LSB = 6;
  localparam int BIT_NREF     = 5;
  localparam int BIT_INVERT   = 3;
  localparam int BIT_SNOOZE   = 2;
  localparam int BIT_RES8     = 0;
  localparam int ST_WINDOW    = 0;
  localparam int ST_END       = 1;

  localparam logic [7:0] TRIGGER_MASK  = 8'hE3;
  localparam logic [7:0] REFCHK_MASK   = 8'hED;
  localparam logic [7:0] RST_TIMING    = 8'h00;
  localparam logic [7:0] RST_TRIGGER   = 8'h00;
  localparam logic [7:0] RST_REFCHK    = 8'h00;
  localparam logic [7:0] RST_UPPER     = 8'hFF;
  localparam logic [7:0] RST_LOWER     = 8'h00;

  localparam logic [COUNT_W-1:0] CONV_CLKS_NORMAL1 = 5'h1B;
  localparam logic [COUNT_W-1:0] CONV_CLKS_NORMAL2 = 5'h19;

  localparam logic [1:0] OPM_NORMAL2   = 2'h1;
  localparam logic [1:0] TSRC_TIMER    = 2'h0;
  localparam logic [1:0] TSRC_CALENDAR = 2'h2;
  localparam logic [1:0] TSRC_INTERVAL = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_WAIT_TRIG = 2'b01,
    ST_CONVERT   = 2'b10
  } conv_state_t;

  function automatic logic [DIV_W-1:0] divisor(input logic [2:0] code);
    case (code)
      3'h0:    divisor = 7'h40;
      3'h1:    divisor = 7'h20;
      3'h2:    divisor = 7'h10;
      3'h3:    divisor = 7'h08;
      3'h4:    divisor = 7'h06;
      3'h5:    divisor = 7'h05;
      3'h6:    divisor = 7'h04;
      default: divisor = 7'h02;
    endcase
  endfunction

endpackage

//--- rtl/adc_clock_divider.sv
/*
  Conversion clock divider: one-cycle tick every divisor() system clocks.
  Assumes the caller holds enable low for a cycle to restart the phase.
*/
`timescale 1ns/1ps
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic       enable,
  input  wire logic [2:0] div_code,
  output logic            tick
);

  logic [DIV_W-1:0] count;
  wire  logic [DIV_W-1:0] last = divisor(div_code) - 7'h01;
  wire  logic             wrap = (count >= last);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        count <= '0;
        tick  <= 1'b0;
      end else begin
        count <= wrap ? '0 : count + 7'h01;
        tick  <= wrap;
      end
    end
  end

endmodule // adc_clock_divider

//--- rtl/adc_mode_trigger_control.sv
/*
  Mode, trigger and limit-check control for a successive-approximation converter.
  Holds the three mode registers and two limit registers, sequences conversions from a
  software or timer trigger, checks each result against the limit window and raises
  the completion interrupt. Assumes single-cycle timer event pulses synchronous to
  CLOCK and an analogue core whose result is valid when the conversion time expires.
*/
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module adc_mode_trigger_control
  import adc_ctrl_pkg::*;
(
  input  wire logic                CLOCK,
  input  wire logic                RESET_N,
  input  wire logic                CE,
  input  wire logic [ADDR_W-1:0]   ADDR,
  input  wire logic [DATA_W-1:0]   WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [DATA_W-1:0]   RDATA,
  input  wire logic                TIMER_CH1_EVENT,
  input  wire logic                CALENDAR_CLOCK_EVENT,
  input  wire logic                INTERVAL_TIMER_EVENT,
  input  wire logic [RESULT_W-1:0] CONVERSION_RESULT,
  output logic                     CONV_CLOCK_TICK,
  output logic                     CONV_START,
  output logic                     CONV_BUSY,
  output logic                     CHANNEL_SCAN_SELECT,
  output logic                     COMPARATOR_ON,
  output logic      [1:0]          OP_MODE,
  output logic      [1:0]          POS_REF_SEL,
  output logic                     NEG_REF_SEL,
  output logic                     SNOOZE_USE,
  output logic                     RESOLUTION_8BIT,
  output logic                     CONVERSION_DONE_IRQ,
  output logic                     IRQ
);

  logic [7:0]          timing_mode_ctrl;
  logic [7:0]          trigger_ctrl;
  logic [7:0]          reference_check_ctrl;
  logic [7:0]          upper_limit_value;
  logic [7:0]          lower_limit_value;
  logic [STATUS_W-1:0] irq_status;
  logic [STATUS_W-1:0] irq_enable;
  conv_state_t         state;
  conv_state_t         next_state;
  logic [COUNT_W-1:0]  conv_count;
  logic                div_tick;

  // Register port decode.
  wire logic wr_timing  = WR && (ADDR == OFS_TIMING);
  wire logic wr_trigger = WR && (ADDR == OFS_TRIGGER);
  wire logic wr_refchk  = WR && (ADDR == OFS_REFCHK);
  wire logic wr_upper   = WR && (ADDR == OFS_UPPER);
  wire logic wr_lower   = WR && (ADDR == OFS_LOWER);
  wire logic wr_clear   = WR && (ADDR == OFS_CLEAR);
  wire logic wr_enable  = WR && (ADDR == OFS_ENABLE);

  // Field views of the mode registers.
  wire logic       conversion_run      = timing_mode_ctrl[BIT_RUN];
  wire logic       comparator_on       = timing_mode_ctrl[BIT_COMP];
  wire logic [2:0] clock_div_sel       = timing_mode_ctrl[FLD_DIV_LSB +: 3];
  wire logic [1:0] op_mode_sel         = timing_mode_ctrl[FLD_OPM_LSB +: 2];
  wire logic [1:0] trigger_mode        = trigger_ctrl[FLD_TRGM_LSB +: 2];
  wire logic       one_shot_select     = trigger_ctrl[BIT_ONESHOT];
  wire logic [1:0] hw_trigger_src      = trigger_ctrl[FLD_TSRC_LSB +: 2];
  wire logic       limit_window_invert = reference_check_ctrl[BIT_INVERT];

  // Software trigger whenever the upper trigger-mode bit is clear.
  wire logic hw_mode = trigger_mode[1];

  // Hardware trigger pick; the unused source code never fires.
  wire logic hw_event =
      (hw_trigger_src == TSRC_TIMER)    ? TIMER_CH1_EVENT :
      (hw_trigger_src == TSRC_CALENDAR) ? CALENDAR_CLOCK_EVENT :
      (hw_trigger_src == TSRC_INTERVAL) ? INTERVAL_TIMER_EVENT : 1'b0;

  // Normal 2 finishes in fewer conversion clocks than Normal 1.
  wire logic [COUNT_W-1:0] conv_len =
      (op_mode_sel == OPM_NORMAL2) ? CONV_CLKS_NORMAL2 : CONV_CLKS_NORMAL1;

  // Conversion proceeds only while the run bit and the comparator are both on.
  wire logic active = conversion_run && comparator_on;

  wire logic conv_end = (state == ST_CONVERT) && active && div_tick
                        && (conv_count == conv_len - 5'h01);

  // In hardware mode a fresh trigger during a conversion restarts it.
  wire logic retrigger = (state == ST_CONVERT) && active && hw_mode && hw_event;

  // Limit window check on the upper eight result bits.
  wire logic [7:0] cmp_value = CONVERSION_RESULT[RESULT_W-1 -: 8];
  wire logic in_window = (cmp_value >= lower_limit_value)
                         && (cmp_value <= upper_limit_value);
  wire logic window_hit = limit_window_invert ? !in_window : in_window;
  wire logic done_event = conv_end && window_hit;

  // Software one-shot completion drops the run bit.
  wire logic clear_run = conv_end && one_shot_select && !hw_mode;

  wire logic [STATUS_W-1:0] events = {conv_end, done_event};
  wire logic [STATUS_W-1:0] clear_bits = wr_clear ? WDATA[STATUS_W-1:0] : '0;

  wire logic [DATA_W-1:0] read_value =
      (ADDR == OFS_TIMING)  ? timing_mode_ctrl :
      (ADDR == OFS_TRIGGER) ? trigger_ctrl :
      (ADDR == OFS_REFCHK)  ? reference_check_ctrl :
      (ADDR == OFS_UPPER)   ? upper_limit_value :
      (ADDR == OFS_LOWER)   ? lower_limit_value :
      (ADDR == OFS_STATUS)  ? {6'h00, irq_status} :
      (ADDR == OFS_ENABLE)  ? {6'h00, irq_enable} : 8'h00;

  // Start pulses are any entry into a conversion or a restart within one.
  wire logic start_now = (next_state == ST_CONVERT)
                         && ((state != ST_CONVERT) || retrigger
                             || (conv_end && !one_shot_select));

  adc_clock_divider u_divider (
    .clock    (CLOCK),
    .reset_n  (RESET_N),
    .ce       (CE),
    .enable   ((state == ST_CONVERT) && !start_now),
    .div_code (clock_div_sel),
    .tick     (div_tick)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (active) begin
          next_state = hw_mode ? ST_WAIT_TRIG : ST_CONVERT;
        end
      end
      ST_WAIT_TRIG: begin
        if (!active || !hw_mode) begin
          next_state = ST_IDLE;
        end else if (hw_event) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!active) begin
          next_state = ST_IDLE;
        end else if (conv_end && one_shot_select && !retrigger) begin
          next_state = hw_mode ? ST_WAIT_TRIG : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= ST_IDLE;
      conv_count <= '0;
    end else if (CE) begin
      state <= next_state;
      if (start_now) begin
        conv_count <= '0;
      end else if ((state == ST_CONVERT) && div_tick) begin
        conv_count <= conv_count + 5'h01;
      end
    end
  end

  // A write to the run bit wins over the hardware clear in the same cycle.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      timing_mode_ctrl <= RST_TIMING;
    end else if (CE) begin
      if (wr_timing) begin
        timing_mode_ctrl <= WDATA;
      end else if (clear_run) begin
        timing_mode_ctrl[BIT_RUN] <= 1'b0;
      end
    end
  end

  // Fixed-zero bits are not stored and read back as zero.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      trigger_ctrl         <= RST_TRIGGER;
      reference_check_ctrl <= RST_REFCHK;
      upper_limit_value    <= RST_UPPER;
      lower_limit_value    <= RST_LOWER;
      irq_enable           <= '0;
    end else if (CE) begin
      if (wr_trigger) begin
        trigger_ctrl <= WDATA & TRIGGER_MASK;
      end
      if (wr_refchk) begin
        reference_check_ctrl <= WDATA & REFCHK_MASK;
      end
      if (wr_upper) begin
        upper_limit_value <= WDATA;
      end
      if (wr_lower) begin
        lower_limit_value <= WDATA;
      end
      if (wr_enable) begin
        irq_enable <= WDATA[STATUS_W-1:0];
      end
    end
  end

  // Sticky status: a new event in the clearing cycle keeps its bit set.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_status <= '0;
    end else if (CE) begin
      irq_status <= (irq_status & ~clear_bits) | events;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= RD ? read_value : '0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONV_CLOCK_TICK     <= 1'b0;
      CONV_START          <= 1'b0;
      CONV_BUSY           <= 1'b0;
      CONVERSION_DONE_IRQ <= 1'b0;
      IRQ                 <= 1'b0;
    end else if (CE) begin
      CONV_CLOCK_TICK     <= div_tick;
      CONV_START          <= start_now;
      CONV_BUSY           <= (next_state == ST_CONVERT);
      CONVERSION_DONE_IRQ <= done_event;
      IRQ                 <= |(((irq_status & ~clear_bits) | events) & irq_enable);
    end
  end

  // Analogue core controls come straight from the mode registers.
  always_comb begin
    CHANNEL_SCAN_SELECT = timing_mode_ctrl[BIT_SCAN];
    COMPARATOR_ON       = comparator_on;
    OP_MODE             = op_mode_sel;
    POS_REF_SEL         = reference_check_ctrl[FLD_PREF_LSB +: 2];
    NEG_REF_SEL         = reference_check_ctrl[BIT_NREF];
    SNOOZE_USE          = reference_check_ctrl[BIT_SNOOZE];
    RESOLUTION_8BIT     = reference_check_ctrl[BIT_RES8];
  end

endmodule // adc_mode_trigger_control

//--- dv/adc_ctrl_props.sv
/*
  Port assertions for the converter mode and trigger control block.
  Assumes it is bound to adc_mode_trigger_control and sees only its ports.
*/
`timescale 1ns/1ps
module adc_ctrl_props
  import adc_ctrl_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              RESET_N,
  input wire logic              CE,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR,
  input wire logic              CONV_START,
  input wire logic              CONV_BUSY,
  input wire logic              CHANNEL_SCAN_SELECT,
  input wire logic              COMPARATOR_ON,
  input wire logic [1:0]        OP_MODE,
  input wire logic [1:0]        POS_REF_SEL,
  input wire logic              NEG_REF_SEL,
  input wire logic              SNOOZE_USE,
  input wire logic              RESOLUTION_8BIT,
  input wire logic              CONVERSION_DONE_IRQ,
  input wire logic              IRQ
);
  wire wr_mode = CE && WR && (ADDR == OFS_TIMING);
  wire wr_ref  = CE && WR && (ADDR == OFS_REFCHK);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  chk_scan_mode: assert property (wr_mode |=> CHANNEL_SCAN_SELECT == $past(WDATA[6]))
    else $error("scan select differs from written bit");
  chk_comp_enable: assert property (wr_mode |=> COMPARATOR_ON == $past(WDATA[0]))
    else $error("comparator enable differs from written bit");
  chk_op_mode: assert property (wr_mode |=> OP_MODE == $past(WDATA[2:1]))
    else $error("operating mode differs from written field");
  chk_pos_ref: assert property (wr_ref |=> POS_REF_SEL == $past(WDATA[7:6]))
    else $error("plus reference differs from written field");
  chk_neg_ref: assert property (wr_ref |=> NEG_REF_SEL == $past(WDATA[5]))
    else $error("minus reference differs from written bit");
  chk_snooze_bit: assert property (wr_ref |=> SNOOZE_USE == $past(WDATA[2]))
    else $error("snooze enable differs from written bit");
  chk_res_width: assert property (wr_ref |=> RESOLUTION_8BIT == $past(WDATA[0]))
    else $error("resolution select differs from written bit");
  chk_start_busy: assert property ($rose(CONV_BUSY) |-> CONV_START)
    else $error("busy rose without a start pulse");
  chk_done_after: assert property (CONVERSION_DONE_IRQ |-> $past(CONV_BUSY))
    else $error("completion pulse outside a conversion");
  cover property (CONV_START);
  cover property (CONVERSION_DONE_IRQ);
  cover property (IRQ);
endmodule // adc_ctrl_props

bind adc_mode_trigger_control adc_ctrl_props u_props (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY), .CHANNEL_SCAN_SELECT(CHANNEL_SCAN_SELECT),
  .COMPARATOR_ON(COMPARATOR_ON), .OP_MODE(OP_MODE), .POS_REF_SEL(POS_REF_SEL),
  .NEG_REF_SEL(NEG_REF_SEL), .SNOOZE_USE(SNOOZE_USE), .RESOLUTION_8BIT(RESOLUTION_8BIT),
  .CONVERSION_DONE_IRQ(CONVERSION_DONE_IRQ), .IRQ(IRQ));

//--- dv/adc_far_model.sv
/*
  Behavioural analogue core and trigger timers.
  Assumes the bench requests timer events one cycle ahead and sets the sample level.
*/
`timescale 1ns/1ps
module adc_far_model (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       conv_busy,
  input  wire logic [9:0] level,
  input  wire logic [2:0] fire,
  output logic      [9:0] result,
  output logic      [2:0] events
);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      events <= 3'h0;
    end else begin
      events <= fire;
    end
  end
  // Outside a conversion the sample is not valid, so its inverse is shown.
  assign result = conv_busy ? level : ~level;
endmodule // adc_far_model

//--- dv/adc_mode_trigger_control_tb_top.sv
/*
  Self-checking bench for the converter mode and trigger control block.
  Assumes the far-side model and the bound port checker.
*/
`timescale 1ns/1ps
module adc_mode_trigger_control_tb_top
  import adc_ctrl_pkg::*;
;
  logic       clock, reset_n, ce, we, re, tick, start, busy, scan, comp, nref, snooze;
  logic       res8, done, irq;
  logic [2:0] addr, events, fire;
  logic [7:0] wdata, rdata;
  logic [9:0] result, level;
  logic [1:0] opm, pref;
  int         bad_count, checked, cyc, n_tick, n_start, n_done, gap, last_tick;
  logic [15:0] dv [8] = '{16'h40, 16'h20, 16'h10, 16'h08, 16'h06, 16'h05, 16'h04, 16'h02};
  logic [9:0]  rv [4] = '{10'h100, 10'h203, 10'h0FF, 10'h204};

  adc_mode_trigger_control dut (.CLOCK(clock), .RESET_N(reset_n), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(we), .RD(re), .RDATA(rdata), .TIMER_CH1_EVENT(events[0]),
    .CALENDAR_CLOCK_EVENT(events[1]), .INTERVAL_TIMER_EVENT(events[2]),
    .CONVERSION_RESULT(result), .CONV_CLOCK_TICK(tick), .CONV_START(start), .CONV_BUSY(busy),
    .CHANNEL_SCAN_SELECT(scan), .COMPARATOR_ON(comp), .OP_MODE(opm), .POS_REF_SEL(pref),
    .NEG_REF_SEL(nref), .SNOOZE_USE(snooze), .RESOLUTION_8BIT(res8),
    .CONVERSION_DONE_IRQ(done), .IRQ(irq));
  adc_far_model far (.clock(clock), .reset_n(reset_n), .conv_busy(busy), .level(level),
    .fire(fire), .result(result), .events(events));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic conclude();
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (tick === 1'b1) begin
      gap = cyc - last_tick;
      last_tick = cyc;
      n_tick++;
    end
    if (start === 1'b1) n_start++;
    if (done === 1'b1) n_done++;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    re <= 1'b1;
    addr <= a;
    @(posedge clock);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic regs();
    logic [7:0] d;
    logic [7:0] rst [5] = '{RST_TIMING, RST_TRIGGER, RST_REFCHK, RST_UPPER, RST_LOWER};
    for (int a = 0; a < 5; a++) begin
      rd(3'(a), d);
      chk({8'h00, d}, {8'h00, rst[a]});
    end
    wr(OFS_TRIGGER, 8'hFF);
    rd(OFS_TRIGGER, d);
    chk({8'h00, d}, 16'h00E3);
    wr(OFS_REFCHK, 8'hFF);
    rd(OFS_REFCHK, d);
    chk({8'h00, d}, 16'h00ED);
    wr(OFS_TIMING, 8'h7E);
    rd(OFS_TIMING, d);
    chk({8'h00, d}, 16'h007E);
    rd(OFS_CLEAR, d);
    chk({8'h00, d}, 16'h0000);
  endtask

  task automatic conv(input logic [2:0] code, input logic [1:0] om, input logic [7:0] lo,
                      input logic [7:0] hi, input logic [9:0] res, input logic inv, hit);
    logic [7:0] d;
    wr(OFS_LOWER, lo);
    wr(OFS_UPPER, hi);
    wr(OFS_REFCHK, {4'h0, inv, 3'h0});
    wr(OFS_CLEAR, 8'h03);
    wr(OFS_TRIGGER, 8'h20);
    @(posedge clock);
    level <= res;
    n_tick = 0;
    n_done = 0;
    wr(OFS_TIMING, {2'b10, code, om, 1'b1});
    for (int i = 0; i < 8 && busy !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    // The last tick and the completion pulse are counted one edge after busy falls.
    @(posedge clock);
    #1;
    chk(16'(n_tick), om[0] ? 16'h0019 : 16'h001B);
    chk(16'(gap), dv[code]);
    chk(16'(n_done), {15'h0, hit});
    rd(OFS_STATUS, d);
    chk({8'h00, d}, {14'h0, 1'b1, hit});
    rd(OFS_TIMING, d);
    chk({8'h00, d}, {8'h00, 2'b00, code, om, 1'b1});
    chk({15'h0, irq}, 16'h0000);
  endtask

  task automatic fire_ev(input logic [2:0] f);
    @(posedge clock);
    fire <= f;
    @(posedge clock);
    fire <= 3'h0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic hw_trig(input logic [1:0] src, input logic [2:0] sel);
    wr(OFS_TRIGGER, {1'b1, src[0], 1'b1, 3'h0, src});
    n_start = 0;
    wr(OFS_TIMING, 8'hB9);
    fire_ev(~sel);
    chk(16'(n_start), 16'h0000);
    fire_ev(sel);
    chk(16'(n_start), {15'h0, |sel});
    wr(OFS_TIMING, 8'h39);
  endtask

  task automatic seq_irq();
    wr(OFS_ENABLE, 8'h02);
    wr(OFS_CLEAR, 8'h03);
    wr(OFS_TRIGGER, 8'h00);
    n_start = 0;
    wr(OFS_TIMING, 8'hBB);
    for (int i = 0; i < 300 && n_start < 2; i++) @(posedge clock);
    #1;
    chk(16'(n_start), 16'h0002);
    chk({15'h0, irq}, 16'h0001);
    wr(OFS_CLEAR, 8'h02);
    @(posedge clock);
    #1;
    chk({15'h0, irq}, 16'h0000);
    wr(OFS_TIMING, 8'h3B);
    repeat (3) @(posedge clock);
    #1;
    chk({15'h0, busy}, 16'h0000);
  endtask

  initial begin
    ce = 1'b1;
    reset_n = 1'b0;
    we = 1'b0;
    re = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    fire = 3'h0;
    level = 10'h000;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    regs();
    for (int c = 0; c < 8; c++) conv(3'(c), {1'b0, c[0]}, 8'h00, 8'hFF, 10'h155, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) conv(3'h7, 2'h0, 8'h40, 8'h80, rv[i%4], i[2], ~i[1] ^ i[2]);
    hw_trig(2'h0, 3'b001);
    hw_trig(2'h1, 3'b000);
    hw_trig(2'h2, 3'b010);
    hw_trig(2'h3, 3'b100);
    seq_irq();
    conclude();
  end
endmodule // adc_mode_trigger_control_tb_top
